// *** rtl/mac_phy_mgmt_and_flow_ctrl.sv ***
// What this block does
// RL1: Host writes PHY address field bits 15-11 as 00001 on every access write.
// RL2: Register index field bits 10-6 selects the PHY register targeted.
// RL3: Bit 1 set means PHY write from data word; clear means read into it.
// RL4: Host starts a management cycle only by writing one to busy bit 0.
// RL5: Host polls busy to zero before writing access or data register.
// RL6: Busy stays one during the whole access; hardware clears it at end.
// RL7: Host keeps data word unchanged during a PHY write until busy clears.
// RL8: Read data word is valid only after busy clears.
// RL9: Data word holds sixteen bits in 15-0, write value or read result.
// RL10: Pause time field 31-16 goes into every sent pause frame.
// RL11: Host loads pause time before enabling full-duplex flow control.
// RL12: Full duplex: send busy set at pause send start, cleared once sent.
// RL13: Half duplex: send busy mirrors back pressure exactly.
// RL14: Host waits for send busy zero and always writes zero to bit 0.
// RL15: Transmitter disabled means no pause frames and no back pressure.
// RL16: Pass bit sets packet filter flag for valid pause frames, else clears.
// RL17: Every received frame's data goes on to the application side.
// RL18: Address filtering modes outrank the pass bit for the filter flag.
// RL19: Full duplex with enable: decode pause, stall transmitter quanta times slot.
// RL20: Enable clear: no pause decoding and no transmitter stall.
// RL21: Half duplex: enable bit turns on back pressure instead.
// RL22: One pause quantum equals 512 bit times at the current link speed.
//
// The AHB-Lite register port is this design's own decision.
module mac_phy_mgmt_and_flow_ctrl #(
	parameter int QUANTUM_CYC_10 = mac_ctrl_pkg::QUANTUM_CYC_10
) (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [7:0]  haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata,
	output logic             mgmt_req,
	output logic             mgmt_write,
	output logic [4:0]       mgmt_phy_addr,
	output logic [4:0]       mgmt_reg_index,
	output logic [15:0]      mgmt_wdata,
	input  wire logic        mgmt_done,
	input  wire logic [15:0] mgmt_rdata,
	input  wire logic        full_duplex,
	input  wire logic        tx_enabled,
	input  wire logic        link_speed_100,
	input  wire logic        pause_request,
	output logic             pause_frame_start,
	output logic [15:0]      pause_frame_time,
	input  wire logic        pause_frame_sent,
	input  wire logic        backpressure_request,
	output logic             backpressure,
	output logic             tx_pause_stall,
	input  wire logic        rx_valid,
	input  wire logic [7:0]  rx_data,
	input  wire logic        rx_last,
	input  wire logic        rx_pause_valid,
	input  wire logic [15:0] rx_pause_quanta,
	input  wire logic        rx_filter_pass,
	input  wire logic        rx_filter_override,
	output logic             rx_out_valid,
	output logic [7:0]       rx_out_data,
	output logic             rx_out_last,
	output logic             rx_status_valid,
	output logic             rx_packet_filter
);

	mac_ctrl_pkg::mgmt_state_e mgmt_state;

	logic        phy_access_busy;
	logic [4:0]  acc_phy_addr;
	logic [4:0]  phy_reg_index;
	logic        phy_write_select;
	logic [15:0] data_word;
	logic [15:0] pause_time_value;
	logic        pass_control_frames;
	logic        pause_function_enable;
	logic        pause_send_busy;
	logic        wr_pend;
	logic        rd_pend;
	logic [7:0]  ph_addr;
	logic        addr_take;
	logic        acc_wr;
	logic        mgmt_start;
	logic        pause_decode_on;
	logic        frame_end;
	logic        timer_stall;
	logic [13:0] quantum_cycles;

	// Address phase taken only with hready high and a live transfer
	assign addr_take = hsel && hready && htrans[1];
	assign acc_wr    = wr_pend && (ph_addr == mac_ctrl_pkg::ADDR_ACCESS);
	// Writes while busy are dropped so an access in flight stays coherent
	assign mgmt_start = acc_wr && !phy_access_busy &&
		hwdata[mac_ctrl_pkg::ACC_BUSY_BIT]; // [RL4]
	assign pause_decode_on = pause_function_enable && full_duplex;
	assign frame_end = rx_valid && rx_last;

	// Bus phase tracking; reads take one wait state
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend   <= 1'b0;
			rd_pend   <= 1'b0;
			ph_addr   <= 8'h00;
			hreadyout <= 1'b1;
		end else begin
			wr_pend <= addr_take && hwrite;
			rd_pend <= addr_take && !hwrite;
			if (addr_take) begin
				ph_addr <= haddr;
			end
			hreadyout <= !(addr_take && !hwrite);
		end
	end

	// Only OKAY responses; unmapped reads give zero
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hresp  <= 1'b0;
			hrdata <= 32'h0000_0000;
		end else if (rd_pend) begin
			unique case (ph_addr)
				mac_ctrl_pkg::ADDR_ACCESS: hrdata <= {16'h0000,
					acc_phy_addr, phy_reg_index, 4'h0,
					phy_write_select, phy_access_busy};
				mac_ctrl_pkg::ADDR_DATA:
					hrdata <= {16'h0000, data_word}; // [RL9]
				mac_ctrl_pkg::ADDR_FLOW: hrdata <= {pause_time_value,
					13'h0000, pass_control_frames,
					pause_function_enable, pause_send_busy};
				default: hrdata <= 32'h0000_0000;
			endcase
		end
	end

	// Access control fields, stored as written when idle
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			acc_phy_addr     <= mac_ctrl_pkg::RST_ACCESS[15:11];
			phy_reg_index    <= mac_ctrl_pkg::RST_ACCESS[10:6];
			phy_write_select <= mac_ctrl_pkg::RST_ACCESS[1];
		end else if (acc_wr && !phy_access_busy) begin
			// PHY address is taken as given; host must supply 00001 [RL1]
			acc_phy_addr  <= hwdata[mac_ctrl_pkg::ACC_PHYADDR_LSB +:
				mac_ctrl_pkg::FIELD5_W];
			phy_reg_index <= hwdata[mac_ctrl_pkg::ACC_INDEX_LSB +:
				mac_ctrl_pkg::FIELD5_W]; // [RL2]
			phy_write_select <= hwdata[mac_ctrl_pkg::ACC_WRITE_BIT];
		end
	end

	// Data word: host writes when idle, read result on completion
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			data_word <= mac_ctrl_pkg::RST_DATA[15:0];
		end else if (mgmt_state == mac_ctrl_pkg::MGMT_ACTIVE &&
			mgmt_done && !phy_write_select) begin
			data_word <= mgmt_rdata; // [RL3] [RL8]
		end else if (wr_pend && ph_addr == mac_ctrl_pkg::ADDR_DATA &&
			!phy_access_busy) begin
			// Held during a write access; busy writes are dropped [RL7]
			data_word <= hwdata[mac_ctrl_pkg::DATA_W-1:0]; // [RL9]
		end
	end

	// Management sequencer; request held until the PHY answers
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			mgmt_state      <= mac_ctrl_pkg::MGMT_IDLE;
			phy_access_busy <= 1'b0;
			mgmt_req        <= 1'b0;
		end else begin
			unique case (mgmt_state)
				mac_ctrl_pkg::MGMT_IDLE: begin
					if (mgmt_start) begin
						mgmt_state      <= mac_ctrl_pkg::MGMT_ACTIVE;
						phy_access_busy <= 1'b1; // [RL6]
						mgmt_req        <= 1'b1;
					end
				end
				mac_ctrl_pkg::MGMT_ACTIVE: begin
					if (mgmt_done) begin
						mgmt_state      <= mac_ctrl_pkg::MGMT_IDLE;
						phy_access_busy <= 1'b0; // [RL6]
						mgmt_req        <= 1'b0;
					end
				end
				default: begin
					mgmt_state      <= mac_ctrl_pkg::MGMT_IDLE;
					phy_access_busy <= 1'b0;
					mgmt_req        <= 1'b0;
				end
			endcase
		end
	end

	// Management command outputs captured at start
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			mgmt_write     <= 1'b0;
			mgmt_phy_addr  <= 5'h00;
			mgmt_reg_index <= 5'h00;
			mgmt_wdata     <= 16'h0000;
		end else if (mgmt_start) begin
			mgmt_write     <= hwdata[mac_ctrl_pkg::ACC_WRITE_BIT]; // [RL3]
			mgmt_phy_addr  <= hwdata[mac_ctrl_pkg::ACC_PHYADDR_LSB +:
				mac_ctrl_pkg::FIELD5_W];
			mgmt_reg_index <= hwdata[mac_ctrl_pkg::ACC_INDEX_LSB +:
				mac_ctrl_pkg::FIELD5_W]; // [RL2]
			mgmt_wdata     <= data_word;
		end
	end

	// Flow control fields; bit 0 is never stored from the bus [RL14]
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pause_time_value      <= mac_ctrl_pkg::RST_FLOW[31:16];
			pass_control_frames   <= mac_ctrl_pkg::RST_FLOW[2];
			pause_function_enable <= mac_ctrl_pkg::RST_FLOW[1];
		end else if (wr_pend && ph_addr == mac_ctrl_pkg::ADDR_FLOW) begin
			pause_time_value <= hwdata[mac_ctrl_pkg::FLOW_PT_LSB +:
				mac_ctrl_pkg::DATA_W]; // [RL11]
			pass_control_frames   <= hwdata[mac_ctrl_pkg::FLOW_PASS_BIT];
			pause_function_enable <= hwdata[mac_ctrl_pkg::FLOW_EN_BIT];
		end
	end

	// Pause send in full duplex, back pressure in half duplex
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pause_send_busy   <= 1'b0;
			pause_frame_start <= 1'b0;
			pause_frame_time  <= 16'h0000;
			backpressure      <= 1'b0;
		end else begin
			pause_frame_start <= 1'b0;
			backpressure <= !full_duplex && pause_function_enable &&
				tx_enabled && backpressure_request; // [RL21] [RL15]
			if (!full_duplex) begin
				pause_send_busy <= pause_function_enable && tx_enabled &&
					backpressure_request; // [RL13]
			end else if (pause_send_busy) begin
				if (pause_frame_sent) begin
					pause_send_busy <= 1'b0; // [RL12]
				end
			end else if (pause_request && tx_enabled) begin // [RL15]
				pause_send_busy   <= 1'b1; // [RL12]
				pause_frame_start <= 1'b1;
				pause_frame_time  <= pause_time_value; // [RL10]
			end
		end
	end

	// Quantum length follows link speed [RL22]
	assign quantum_cycles = link_speed_100 ?
		14'(mac_ctrl_pkg::QUANTUM_CYC_100) : 14'(QUANTUM_CYC_10);

	// Pause decoding only with enable in full duplex [RL19] [RL20]
	pause_stall_timer u_stall (
		.hclk           (hclk),
		.hresetn        (hresetn),
		.load           (frame_end && rx_pause_valid && pause_decode_on),
		.clear          (!pause_decode_on),
		.quanta         (rx_pause_quanta),
		.quantum_cycles (quantum_cycles),
		.stall          (timer_stall)
	);

	// Registered transmitter stall
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			tx_pause_stall <= 1'b0;
		end else begin
			tx_pause_stall <= timer_stall; // [RL19]
		end
	end

	// Every frame passes through, control and errored ones too [RL17]
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rx_out_valid <= 1'b0;
			rx_out_data  <= 8'h00;
			rx_out_last  <= 1'b0;
		end else begin
			rx_out_valid <= rx_valid;
			rx_out_data  <= rx_data;
			rx_out_last  <= rx_valid && rx_last;
		end
	end

	// Filter flag: filter modes first, then pass bit for pause frames
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rx_status_valid  <= 1'b0;
			rx_packet_filter <= 1'b0;
		end else begin
			rx_status_valid <= frame_end;
			if (frame_end) begin
				if (rx_filter_override) begin
					rx_packet_filter <= 1'b1; // [RL18]
				end else if (rx_pause_valid) begin
					rx_packet_filter <= pass_control_frames; // [RL16]
				end else begin
					rx_packet_filter <= rx_filter_pass;
				end
			end
		end
	end

	// Checks
	a_req_has_busy: assert property (@(posedge hclk) // [RL6]
		disable iff (!hresetn) mgmt_req |-> phy_access_busy)
		else $error("request without busy");
	a_busy_until_done: assert property (@(posedge hclk) // [RL6]
		disable iff (!hresetn)
		phy_access_busy && !mgmt_done |=> phy_access_busy)
		else $error("busy dropped early");
	a_done_clears: assert property (@(posedge hclk) // [RL6]
		disable iff (!hresetn)
		mgmt_req && mgmt_done |=> !phy_access_busy && !mgmt_req)
		else $error("busy not cleared");
	a_read_capture: assert property (@(posedge hclk) // [RL3]
		disable iff (!hresetn)
		mgmt_req && mgmt_done && !mgmt_write
		|=> data_word == $past(mgmt_rdata))
		else $error("read data not captured");
	a_index_drives: assert property (@(posedge hclk) // [RL2]
		disable iff (!hresetn) mgmt_req |-> mgmt_reg_index == phy_reg_index)
		else $error("index mismatch");
	// A flow write may land on the start edge, so compare the older value
	a_pause_time: assert property (@(posedge hclk) // [RL10]
		disable iff (!hresetn) pause_frame_start |->
		pause_send_busy && pause_frame_time == $past(pause_time_value))
		else $error("pause time wrong");
	a_txoff_quiet: assert property (@(posedge hclk) // [RL15]
		disable iff (!hresetn)
		!tx_enabled |=> !backpressure && !pause_frame_start)
		else $error("flow control with tx off");
	a_half_busy: assert property (@(posedge hclk) // [RL13]
		disable iff (!hresetn)
		$past(!full_duplex) |-> pause_send_busy == backpressure)
		else $error("busy not tracking back pressure");
	a_no_decode: assert property (@(posedge hclk) // [RL20]
		disable iff (!hresetn) !pause_function_enable ##1
		!pause_function_enable |=> !tx_pause_stall)
		else $error("stall with decode off");
	a_filter_rank: assert property (@(posedge hclk) // [RL18]
		disable iff (!hresetn)
		frame_end && rx_filter_override |=> rx_packet_filter)
		else $error("filter override lost");
	a_read_wait: assert property (@(posedge hclk) disable iff (!hresetn)
		addr_take && !hwrite |=> !hreadyout ##1 hreadyout)
		else $error("read wait state wrong");

	c_phy_read: cover property (@(posedge hclk) disable iff (!hresetn)
		mgmt_req && mgmt_done && !mgmt_write);
	c_pause_sent: cover property (@(posedge hclk) disable iff (!hresetn)
		pause_send_busy && pause_frame_sent);
	c_stall: cover property (@(posedge hclk) disable iff (!hresetn)
		$rose(tx_pause_stall));
	c_bp: cover property (@(posedge hclk) disable iff (!hresetn)
		$rose(backpressure));

endmodule : mac_phy_mgmt_and_flow_ctrl

// *** rtl/mac_ctrl_pkg.sv ***
package mac_ctrl_pkg;

	// Register indices; byte address is four times the index
	localparam logic [7:0] IDX_ACCESS   = 8'h06;
	localparam logic [7:0] IDX_DATA     = 8'h07;
	localparam logic [7:0] IDX_FLOW     = 8'h08;
	localparam logic [7:0] ADDR_ACCESS  = 8'(IDX_ACCESS * 4);
	localparam logic [7:0] ADDR_DATA    = 8'(IDX_DATA * 4);
	localparam logic [7:0] ADDR_FLOW    = 8'(IDX_FLOW * 4);

	// Access control field positions
	localparam int ACC_PHYADDR_LSB = 11;
	localparam int ACC_INDEX_LSB   = 6;
	localparam int ACC_WRITE_BIT   = 1;
	localparam int ACC_BUSY_BIT    = 0;
	localparam int FIELD5_W        = 5;
	localparam int DATA_W          = 16;

	// Flow control field positions
	localparam int FLOW_PT_LSB    = 16;
	localparam int FLOW_PASS_BIT  = 2;
	localparam int FLOW_EN_BIT    = 1;
	localparam int FLOW_BUSY_BIT  = 0;

	// Reset values
	localparam logic [31:0] RST_ACCESS = 32'h0000_0000;
	localparam logic [31:0] RST_DATA   = 32'h0000_0000;
	localparam logic [31:0] RST_FLOW   = 32'h0000_0000;

	// Timing: one pause quantum is 512 bit times
	localparam int CLK_PERIOD_NS    = 4;
	localparam int QUANTUM_BITS     = 512;
	localparam int BIT_TIME_NS_100  = 10;
	localparam int BIT_TIME_NS_10   = 100;
	localparam int QUANTUM_CYC_100  =
		(QUANTUM_BITS * BIT_TIME_NS_100) / CLK_PERIOD_NS;
	localparam int QUANTUM_CYC_10   =
		(QUANTUM_BITS * BIT_TIME_NS_10) / CLK_PERIOD_NS;
	localparam int QCNT_W           = 14;

	// Management sequencer states
	typedef enum logic [1:0] {
		MGMT_IDLE   = 2'b01,
		MGMT_ACTIVE = 2'b10
	} mgmt_state_e;

endpackage : mac_ctrl_pkg

// *** rtl/pause_stall_timer.sv ***
module pause_stall_timer (
	input  wire logic                               hclk,
	input  wire logic                               hresetn,
	input  wire logic                               load,
	input  wire logic                               clear,
	input  wire logic [mac_ctrl_pkg::DATA_W-1:0]    quanta,
	input  wire logic [mac_ctrl_pkg::QCNT_W-1:0]    quantum_cycles,
	output logic                                    stall
);

	logic [mac_ctrl_pkg::DATA_W-1:0] quanta_left;
	logic [mac_ctrl_pkg::QCNT_W-1:0] cyc;

	// New pause replaces the old one; zero quanta resumes at once
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			quanta_left <= 16'h0000;
			cyc         <= 14'h0000;
		end else if (clear) begin
			quanta_left <= 16'h0000;
			cyc         <= 14'h0000;
		end else if (load) begin
			quanta_left <= quanta;
			cyc         <= 14'h0000;
		end else if (quanta_left != 16'h0000) begin
			if (cyc == quantum_cycles - 14'h0001) begin
				cyc         <= 14'h0000;
				quanta_left <= quanta_left - 16'h0001;
			end else begin
				cyc <= cyc + 14'h0001;
			end
		end
	end

	// Stall while quanta remain
	assign stall = (quanta_left != 16'h0000);

endmodule : pause_stall_timer

// *** tb/phy_model.sv ***
module phy_model (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic [3:0]  delay,
	input  wire logic        mgmt_req,
	input  wire logic        mgmt_write,
	input  wire logic [4:0]  mgmt_reg_index,
	input  wire logic [15:0] mgmt_wdata,
	output logic             mgmt_done,
	output logic [15:0]      mgmt_rdata
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] regs [32];
	logic [3:0]  cnt;
	logic        served;

	// One done pulse per request after a set delay; read lines scramble
	// between answers so stale data never looks valid
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt <= 4'h0;
			served <= 1'b0;
			mgmt_done <= 1'b0;
			mgmt_rdata <= 16'h0000;
			for (int i = 0; i < 32; i++) regs[i] <= 16'h0000;
		end else begin
			mgmt_done <= 1'b0;
			mgmt_rdata <= ~mgmt_rdata;
			if (!mgmt_req) begin
				served <= 1'b0;
				cnt <= 4'h0;
			end else if (!served && cnt == delay) begin
				served <= 1'b1;
				mgmt_done <= 1'b1;
				if (mgmt_write) regs[mgmt_reg_index] <= mgmt_wdata;
				else mgmt_rdata <= regs[mgmt_reg_index];
			end else if (!served) begin
				cnt <= cnt + 4'h1;
			end
		end
	end
endmodule : phy_model

// *** tb/mac_phy_mgmt_and_flow_ctrl_tb_top.sv ***
module mac_phy_mgmt_and_flow_ctrl_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int QC = 4;
	localparam int QC100 = mac_ctrl_pkg::QUANTUM_CYC_100;
	logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
	logic        mgmt_req, mgmt_write, mgmt_done, full_duplex, tx_enabled;
	logic        link_speed_100, pause_request, pause_frame_start;
	logic        pause_frame_sent, backpressure_request, backpressure;
	logic        tx_pause_stall, rx_valid, rx_last, rx_pause_valid;
	logic        rx_filter_pass, rx_filter_override, rx_out_valid;
	logic        rx_out_last, rx_status_valid, rx_packet_filter;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [3:0]  phy_delay;
	logic [4:0]  mgmt_phy_addr, mgmt_reg_index;
	logic [7:0]  haddr, rx_data, rx_out_data;
	logic [15:0] mgmt_wdata, mgmt_rdata, pause_frame_time, rx_pause_quanta;
	logic [31:0] hwdata, hrdata, rd;
	int          failures, tests_run, n;

	mac_phy_mgmt_and_flow_ctrl #(.QUANTUM_CYC_10(QC)) u_dut (
		.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
		.hready(hreadyout), .hreadyout, .hresp, .hrdata, .mgmt_req,
		.mgmt_write, .mgmt_phy_addr, .mgmt_reg_index, .mgmt_wdata,
		.mgmt_done, .mgmt_rdata, .full_duplex, .tx_enabled, .link_speed_100,
		.pause_request, .pause_frame_start, .pause_frame_time,
		.pause_frame_sent, .backpressure_request, .backpressure,
		.tx_pause_stall, .rx_valid, .rx_data, .rx_last, .rx_pause_valid,
		.rx_pause_quanta, .rx_filter_pass, .rx_filter_override, .rx_out_valid,
		.rx_out_data, .rx_out_last, .rx_status_valid, .rx_packet_filter
	);
	phy_model u_phy (
		.hclk, .hresetn, .delay(phy_delay), .mgmt_req, .mgmt_write,
		.mgmt_reg_index, .mgmt_wdata, .mgmt_done, .mgmt_rdata
	);

	// Free-running bus clock
	always #2 hclk = ~hclk;

	task automatic conclude();
		$display("comparisons %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : conclude

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			failures++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// Bounded wait for hready at a rising edge
	task automatic wait_ready();
		n = 0;
		do begin
			@(posedge hclk);
			n++;
		end while (hreadyout !== 1'b1 && n < 64);
		if (hreadyout !== 1'b1) begin
			failures++;
			conclude();
		end
	endtask : wait_ready

	// Single word transfer; entered just after a rising edge
	task automatic ahb(input logic wr, input logic [7:0] a,
		input logic [31:0] wd);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= a;
		hwrite <= wr;
		wait_ready();
		htrans <= 2'b00;
		hsel <= 1'b0;
		hwdata <= wd;
		wait_ready();
		rd = hrdata;
	endtask : ahb

	task automatic rdchk(input logic [7:0] a, input logic [31:0] mask,
		input logic [31:0] exp);
		ahb(1'b0, a, 32'h0000_0000);
		chk(rd & mask, exp);
		chk({31'h0, hresp}, 32'h0);
	endtask : rdchk

	// Busy bit polled under a bound
	task automatic poll(input logic [7:0] a);
		for (int i = 0; i < 64; i++) begin
			ahb(1'b0, a, 32'h0000_0000);
			if (rd[0] === 1'b0) return;
		end
		failures++;
		conclude();
	endtask : poll

	// A write also tries to disturb the data word while busy
	task automatic phy(input logic wr, input logic [4:0] idx,
		input logic [15:0] d);
		if (wr) ahb(1'b1, mac_ctrl_pkg::ADDR_DATA, {16'h0000, d});
		ahb(1'b1, mac_ctrl_pkg::ADDR_ACCESS,
			{16'h0000, 5'b00001, idx, 4'h0, wr, 1'b1});
		rdchk(mac_ctrl_pkg::ADDR_ACCESS, 32'h1, 32'h1);
		chk({21'h0, mgmt_write, mgmt_phy_addr, mgmt_reg_index},
			{21'h0, wr, 5'b00001, idx});
		if (wr) ahb(1'b1, mac_ctrl_pkg::ADDR_DATA, 32'h0000_DEAD);
		poll(mac_ctrl_pkg::ADDR_ACCESS);
		if (wr) rdchk(mac_ctrl_pkg::ADDR_DATA, 32'hFFFF, {16'h0000, d});
	endtask : phy

	// Single-byte frame, then filter flag and stall length
	task automatic frame(input logic pv, input logic ov, input logic fp,
		input logic [15:0] q, input logic filt, input int stall);
		int cnt;
		cnt = 0;
		rx_valid <= 1'b1;
		rx_data <= 8'hC3;
		rx_last <= 1'b1;
		rx_pause_valid <= pv;
		rx_pause_quanta <= q;
		rx_filter_override <= ov;
		rx_filter_pass <= fp;
		@(posedge hclk);
		rx_valid <= 1'b0;
		rx_last <= 1'b0;
		#1 chk({rx_out_valid, rx_out_last, rx_out_data}, 32'h3C3);
		for (int i = 0; i < 4 && rx_status_valid !== 1'b1; i++) #4;
		chk({rx_status_valid, rx_packet_filter}, {30'h0, 1'b1, filt});
		for (int i = 0; i < stall + 8; i++) begin
			@(posedge hclk);
			cnt += int'(tx_pause_stall === 1'b1);
		end
		chk(32'(cnt >= stall && cnt <= stall + 2), 32'h1);
	endtask : frame

	initial begin
		hclk = 0;
		hresetn = 0;
		hsel = 0;
		haddr = 8'h00;
		htrans = 2'b00;
		hwrite = 0;
		hsize = 3'b010;
		hwdata = 32'h0000_0000;
		phy_delay = 4'h6;
		full_duplex = 1;
		tx_enabled = 1;
		link_speed_100 = 0;
		pause_request = 0;
		pause_frame_sent = 0;
		backpressure_request = 0;
		rx_valid = 0;
		rx_data = 8'h00;
		rx_last = 0;
		rx_pause_valid = 0;
		rx_pause_quanta = 16'h0000;
		rx_filter_pass = 0;
		rx_filter_override = 0;
		failures = 0;
		tests_run = 0;
		repeat (10) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		// Reset values, unmapped place reads zero and ignores writes
		rdchk(mac_ctrl_pkg::ADDR_ACCESS, '1, mac_ctrl_pkg::RST_ACCESS);
		rdchk(mac_ctrl_pkg::ADDR_DATA, '1, mac_ctrl_pkg::RST_DATA);
		rdchk(mac_ctrl_pkg::ADDR_FLOW, '1, mac_ctrl_pkg::RST_FLOW);
		ahb(1'b1, 8'h24, 32'hFFFF_FFFF);
		rdchk(8'h24, '1, 32'h0000_0000);
		$display("test registers done");
		// Two indices written then read back separately
		phy(1'b1, 5'd3, 16'hA5C3);
		phy(1'b1, 5'd17, 16'h5A3C);
		phy(1'b0, 5'd3, 16'h0000);
		rdchk(mac_ctrl_pkg::ADDR_DATA, '1, 32'h0000_A5C3);
		phy(1'b0, 5'd17, 16'h0000);
		rdchk(mac_ctrl_pkg::ADDR_DATA, '1, 32'h0000_5A3C);
		rdchk(mac_ctrl_pkg::ADDR_ACCESS, '1, 32'h0000_0C40);
		ahb(1'b1, mac_ctrl_pkg::ADDR_ACCESS, 32'h0000_0802);
		repeat (3) @(posedge hclk);
		chk({31'h0, mgmt_req}, 32'h0);
		$display("test phy access done");
		// Pause send; time loaded before enable, bit 0 always zero
		ahb(1'b1, mac_ctrl_pkg::ADDR_FLOW, 32'h1234_0000);
		ahb(1'b1, mac_ctrl_pkg::ADDR_FLOW, 32'h1234_0002);
		rdchk(mac_ctrl_pkg::ADDR_FLOW, '1, 32'h1234_0002);
		pause_request <= 1'b1;
		@(posedge hclk);
		pause_request <= 1'b0;
		#1 chk({pause_frame_start, pause_frame_time}, 32'h1_1234);
		@(posedge hclk);
		rdchk(mac_ctrl_pkg::ADDR_FLOW, 32'h1, 32'h1);
		pause_frame_sent <= 1'b1;
		@(posedge hclk);
		pause_frame_sent <= 1'b0;
		rdchk(mac_ctrl_pkg::ADDR_FLOW, 32'h1, 32'h0);
		tx_enabled <= 1'b0;
		pause_request <= 1'b1;
		@(posedge hclk);
		pause_request <= 1'b0;
		#1 chk({31'h0, pause_frame_start}, 32'h0);
		$display("test pause send done");
		// Half duplex back pressure, gated by transmitter and enable
		full_duplex <= 1'b0;
		backpressure_request <= 1'b1;
		repeat (3) @(posedge hclk);
		chk({31'h0, backpressure}, 32'h0);
		tx_enabled <= 1'b1;
		repeat (3) @(posedge hclk);
		chk({31'h0, backpressure}, 32'h1);
		rdchk(mac_ctrl_pkg::ADDR_FLOW, 32'h1, 32'h1);
		backpressure_request <= 1'b0;
		repeat (3) @(posedge hclk);
		rdchk(mac_ctrl_pkg::ADDR_FLOW, 32'h1, 32'h0);
		ahb(1'b1, mac_ctrl_pkg::ADDR_FLOW, 32'h0000_0000);
		backpressure_request <= 1'b1;
		repeat (3) @(posedge hclk);
		chk({31'h0, backpressure}, 32'h0);
		backpressure_request <= 1'b0;
		full_duplex <= 1'b1;
		$display("test back pressure done");
		// Received pause frames: filter flag and stall length
		ahb(1'b1, mac_ctrl_pkg::ADDR_FLOW, 32'h0000_0006);
		frame(1'b1, 1'b0, 1'b0, 16'd3, 1'b1, 3 * QC);
		ahb(1'b1, mac_ctrl_pkg::ADDR_FLOW, 32'h0000_0002);
		frame(1'b1, 1'b1, 1'b0, 16'd1, 1'b1, QC);
		frame(1'b1, 1'b0, 1'b1, 16'd2, 1'b0, 2 * QC);
		frame(1'b0, 1'b0, 1'b1, 16'd5, 1'b1, 0);
		link_speed_100 <= 1'b1;
		frame(1'b1, 1'b0, 1'b1, 16'd1, 1'b0, QC100);
		link_speed_100 <= 1'b0;
		ahb(1'b1, mac_ctrl_pkg::ADDR_FLOW, 32'h0000_0000);
		frame(1'b1, 1'b0, 1'b0, 16'd3, 1'b0, 0);
		$display("test receive pause done");
		conclude();
	end
endmodule : mac_phy_mgmt_and_flow_ctrl_tb_top
